// >>> src/hcwa_pkg.sv
package hcwa_pkg;
  // ****************************************
  // Code word layout
  // ****************************************
  localparam int HOP_W = 32;
  localparam int FIXED_W = 32;
  localparam int STATUS_SHORT_W = 3;
  localparam int STATUS_LONG_W = 5;
  localparam int FRAME_W = HOP_W + FIXED_W + STATUS_LONG_W;
  localparam logic [6:0] WORD_LEN_SHORT = 7'(HOP_W + FIXED_W + STATUS_SHORT_W);
  localparam logic [6:0] WORD_LEN_LONG = 7'(HOP_W + FIXED_W + STATUS_LONG_W);
  localparam logic [6:0] FIXED_START = 7'(HOP_W);
  localparam int SERIAL_W = 32;
  localparam int SERIAL_SHORT_W = 28;
  localparam int FUNC_W = 4;
  localparam int BUTTONS = 6;
  localparam int DISCRIMINATION_VALUE_W = 10;
  localparam int COUNT_W = 20;

  // ****************************************
  // Hopping portion fields, short counter
  // ****************************************
  localparam int CNT_SHORT_W = 16;
  localparam int DISCRIMINATION_VALUE_SHORT_LSB = 16;
  localparam int DISCRIMINATION_VALUE_LONG_W = 10;
  localparam int OVF_LSB = 26;
  localparam int FUNC_LSB = 28;

  // ****************************************
  // Hopping portion fields, long counter
  // ****************************************
  localparam int DISCRIMINATION_VALUE_WIDE_LSB = 20;
  localparam int DISCRIMINATION_VALUE_NARROW_W = 8;

  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int ST_LOW = 0;
  localparam int ST_CHK_LSB = 1;
  localparam int ST_QUE_LSB = 3;

  localparam logic [COUNT_W-1:0] COUNT_ZERO = 20'h00000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 20'h00001;
  localparam logic [COUNT_W-1:0] COUNT_WIDE_MAX = 20'hfffff;
  localparam logic [CNT_SHORT_W-1:0] COUNT_SHORT_MAX = 16'hffff;
  localparam logic [1:0] OVF_RESET = 2'h3;
  localparam int FIFO_DEPTH = 8;

  // Code of each button, indexed by button number
  localparam logic [BUTTONS-1:0][FUNC_W-1:0] BUTTON_CODE = {
    4'hd, 4'he, 4'h1, 4'h8, 4'h4, 4'h2
  };

  typedef enum logic [3:0] {
    IDLE = 4'h1,
    CRYPT = 4'h2,
    RAMP = 4'h4,
    SEND = 4'h8
  } phase_type;
endpackage

// >>> src/bit_fifo.sv
`timescale 1ns/1ps
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [CNT_W-1:0] count;
  } fifo_type;

  fifo_type s;
  fifo_type next_s;
  logic push;
  logic pop;

  assign inReady = s.count != FULL;
  assign outValid = s.count != '0;
  assign outData = s.mem[s.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wrPtr] = inData;
      next_s.wrPtr = (s.wrPtr == LAST) ? '0 : s.wrPtr + PTR_ONE;
    end
    if (pop) begin
      next_s.rdPtr = (s.rdPtr == LAST) ? '0 : s.rdPtr + PTR_ONE;
    end
    if (push && !pop) begin
      next_s.count = s.count + CNT_ONE;
    end else if (pop && !push) begin
      next_s.count = s.count - CNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// >>> src/hopping_code_word_assembler.sv
`timescale 1ns/1ps
module hopping_code_word_assembler #(
  parameter int DEPTH = hcwa_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Buttons and configuration select
  input wire logic shift,
  input wire logic pressDone,
  input wire logic [hcwa_pkg::BUTTONS-1:0] buttons,
  input wire logic resend,
  output logic busy,
  // Per-configuration stored values, index 0 is the first configuration
  input wire logic [1:0][hcwa_pkg::SERIAL_W-1:0] serialNumber,
  input wire logic [1:0][hcwa_pkg::DISCRIMINATION_VALUE_W-1:0] discriminationValue,
  input wire logic [1:0] extendedSerialOption,
  input wire logic [1:0] queueBitsOption,
  // Device options
  input wire logic counterWidthOption,
  input wire logic lowSupplyLatchOption,
  input wire logic tripPointOption,
  input wire logic waitOption,
  // Counter programming
  input wire logic progWrite,
  input wire logic progSel,
  input wire logic [hcwa_pkg::COUNT_W-1:0] progCount,
  input wire logic [1:0] progOverflow,
  // Supply monitor and regulator
  input wire logic lowSupplyRaw,
  output logic tripHigh,
  output logic lowSupplyFlag,
  input wire logic regulatorReady,
  input wire logic [1:0] queueCount,
  // Cipher engine
  output logic cipherReq,
  output logic cipherKeySel,
  output logic [hcwa_pkg::HOP_W-1:0] cipherData,
  input wire logic cipherDone,
  input wire logic [hcwa_pkg::HOP_W-1:0] cipherResult,
  // Held word and counter state
  output logic [hcwa_pkg::HOP_W-1:0] hopCode,
  output logic [hcwa_pkg::COUNT_W-1:0] wordCount,
  output logic [1:0][1:0] overflowState,
  // Serial bit stream
  output logic txValid,
  input wire logic txReady,
  output logic txBit
);
  import hcwa_pkg::*;

  typedef struct packed {
    phase_type phase;
    logic [1:0][COUNT_W-1:0] syncCount;
    logic [1:0][1:0] overflowFlags;
    logic cfg;
    logic [FUNC_W-1:0] funcCode;
    logic [HOP_W-1:0] plain;
    logic [HOP_W-1:0] hop;
    logic [FIXED_W-1:0] fixedPart;
    logic [STATUS_LONG_W-1:0] status;
    logic [6:0] bitIdx;
    logic [6:0] wordLen;
    logic cipherReq;
    logic lowLatch;
    logic haveWord;
  } core_type;

  core_type s;
  core_type next_s;
  logic [FUNC_W-1:0] pressCode;
  logic [COUNT_W-1:0] curCount;
  logic [COUNT_W-1:0] newCount;
  logic [1:0] newFlags;
  logic wrapShort;
  logic [HOP_W-1:0] newPlain;
  logic [FIXED_W-1:0] newFixed;
  logic [STATUS_LONG_W-1:0] newStatus;
  logic [FRAME_W-1:0] frame;
  logic pushValid;
  logic pushReady;
  logic pushBit;

  // ****************************************
  // Function code
  // ****************************************
  always_comb begin
    pressCode = '0;
    for (int i = 0; i < BUTTONS; i++) begin
      if (buttons[i]) begin
        pressCode = pressCode | BUTTON_CODE[i];
      end
    end
  end

  // ****************************************
  // Counter advance of the selected configuration
  // ****************************************
  always_comb begin
    curCount = s.syncCount[shift];
    newFlags = s.overflowFlags[shift];
    wrapShort = curCount[CNT_SHORT_W-1:0] == COUNT_SHORT_MAX;
    if (counterWidthOption) begin
      newCount = (curCount == COUNT_WIDE_MAX) ? COUNT_ZERO : curCount + COUNT_ONE;
    end else begin
      newCount = {4'h0, curCount[CNT_SHORT_W-1:0] + 16'h0001};
      if (wrapShort) begin
        // A flag already clear stays clear, so two wraps are all it can show
        if (newFlags[0]) begin
          newFlags[0] = 1'b0;
        end else begin
          newFlags[1] = 1'b0;
        end
      end
    end
    newPlain = '0;
    newPlain[FUNC_LSB +: FUNC_W] = pressCode;
    if (counterWidthOption) begin
      newPlain[COUNT_W-1:0] = newCount;
      newPlain[DISCRIMINATION_VALUE_WIDE_LSB +: DISCRIMINATION_VALUE_NARROW_W] = discriminationValue[shift][DISCRIMINATION_VALUE_NARROW_W-1:0];
    end else begin
      newPlain[CNT_SHORT_W-1:0] = newCount[CNT_SHORT_W-1:0];
      newPlain[DISCRIMINATION_VALUE_SHORT_LSB +: DISCRIMINATION_VALUE_LONG_W] = discriminationValue[shift];
      newPlain[OVF_LSB +: 2] = newFlags;
    end
  end

  // ****************************************
  // Fixed portion and status
  // ****************************************
  always_comb begin
    if (extendedSerialOption[s.cfg]) begin
      newFixed = serialNumber[s.cfg];
    end else begin
      newFixed = {s.funcCode, serialNumber[s.cfg][SERIAL_SHORT_W-1:0]};
    end
    newStatus = '0;
    newStatus[ST_LOW] = lowSupplyFlag;
    newStatus[ST_CHK_LSB] = ^s.hop;
    newStatus[ST_CHK_LSB+1] = ^s.fixedPart;
    if (queueBitsOption[s.cfg]) begin
      newStatus[ST_QUE_LSB +: 2] = queueCount;
    end
  end

  assign frame = {s.status, s.fixedPart, s.hop};
  assign pushBit = frame[s.bitIdx];
  assign pushValid = s.phase == SEND;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.cipherReq = 1'b0;
    // Latch only follows the detector while the option is on
    next_s.lowLatch = lowSupplyLatchOption && (s.lowLatch || lowSupplyRaw);
    unique case (s.phase)
      IDLE: begin
        if (pressDone) begin
          next_s.cfg = shift;
          next_s.funcCode = pressCode;
          next_s.syncCount[shift] = newCount;
          next_s.overflowFlags[shift] = newFlags;
          next_s.plain = newPlain;
          next_s.cipherReq = 1'b1;
          next_s.phase = CRYPT;
        end else if (progWrite) begin
          next_s.syncCount[progSel] = progCount;
          next_s.overflowFlags[progSel] = progOverflow;
        end else if (resend && s.haveWord) begin
          next_s.status = newStatus;
          next_s.bitIdx = '0;
          next_s.phase = RAMP;
        end
      end
      CRYPT: begin
        if (cipherDone) begin
          next_s.hop = cipherResult;
          next_s.haveWord = 1'b1;
          next_s.phase = RAMP;
          next_s.bitIdx = '0;
          next_s.fixedPart = newFixed;
          next_s.status[ST_LOW] = lowSupplyFlag;
          next_s.status[ST_CHK_LSB] = ^cipherResult;
          next_s.status[ST_CHK_LSB+1] = ^next_s.fixedPart;
          next_s.status[ST_QUE_LSB +: 2] = queueBitsOption[s.cfg] ? queueCount : 2'h0;
        end
      end
      RAMP: begin
        next_s.wordLen = queueBitsOption[s.cfg] ? WORD_LEN_LONG : WORD_LEN_SHORT;
        if (!waitOption || regulatorReady) begin
          next_s.phase = SEND;
        end
      end
      SEND: begin
        if (pushReady) begin
          next_s.bitIdx = s.bitIdx + 7'h01;
          if (s.bitIdx == s.wordLen - 7'h01) begin
            next_s.phase = IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.phase <= IDLE;
      s.overflowFlags <= {OVF_RESET, OVF_RESET};
      s.wordLen <= WORD_LEN_SHORT;
    end else begin
      s <= next_s;
    end
  end

  // Decouples the sequencer from a modulator that may stall at any bit
  bit_fifo #(
    .WIDTH(1),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushBit),
    .outValid(txValid),
    .outReady(txReady),
    .outData(txBit)
  );

  assign busy = s.phase != IDLE;
  assign tripHigh = tripPointOption;
  assign lowSupplyFlag = s.lowLatch || lowSupplyRaw;
  assign cipherReq = s.cipherReq;
  assign cipherKeySel = s.cfg;
  assign cipherData = s.plain;
  assign hopCode = s.hop;
  assign wordCount = s.syncCount[s.cfg];
  assign overflowState = s.overflowFlags;

  // ****************************************
  // Checks
  // ****************************************
  property p_cfgSelect;
    @(posedge clk) disable iff (!rst_b)
    (s.phase == IDLE && pressDone) |=> (cipherKeySel == $past(shift) && cipherReq);
  endproperty
  a_cfgSelect: assert property (p_cfgSelect) else $error("wrong configuration used");

  property p_hopHold;
    @(posedge clk) disable iff (!rst_b)
    !(s.phase == CRYPT && cipherDone) |=> $stable(hopCode);
  endproperty
  a_hopHold: assert property (p_hopHold) else $error("hop changed between presses");

  property p_short;
    @(posedge clk) disable iff (!rst_b)
    (cipherReq && !counterWidthOption) |->
      (cipherData[CNT_SHORT_W-1:0] == wordCount[CNT_SHORT_W-1:0] &&
       cipherData[OVF_LSB +: 2] == overflowState[s.cfg]);
  endproperty
  a_short: assert property (p_short) else $error("short counter layout wrong");

  property p_wide;
    @(posedge clk) disable iff (!rst_b)
    (cipherReq && counterWidthOption) |->
      (cipherData[COUNT_W-1:0] == wordCount && cipherData[FUNC_LSB +: FUNC_W] == s.funcCode);
  endproperty
  a_wide: assert property (p_wide) else $error("long counter layout wrong");

  property p_flagsFall;
    @(posedge clk) disable iff (!rst_b)
    !$past(progWrite) |-> ((overflowState & ~$past(overflowState)) == 4'h0);
  endproperty
  a_flagsFall: assert property (p_flagsFall) else $error("overflow flag set again");

  property p_wordLen;
    @(posedge clk) disable iff (!rst_b)
    (s.phase == SEND) |-> (s.wordLen == (queueBitsOption[s.cfg] ? WORD_LEN_LONG : WORD_LEN_SHORT));
  endproperty
  a_wordLen: assert property (p_wordLen) else $error("status length wrong");

  property p_order;
    @(posedge clk) disable iff (!rst_b)
    (pushValid && s.bitIdx == FIXED_START) |-> (pushBit == s.fixedPart[0]);
  endproperty
  a_order: assert property (p_order) else $error("fixed part out of place");

  property p_lsbFirst;
    @(posedge clk) disable iff (!rst_b)
    $rose(pushValid) |-> (s.bitIdx == 7'h00 && pushBit == hopCode[0]);
  endproperty
  a_lsbFirst: assert property (p_lsbFirst) else $error("first bit not hop lsb");

  property p_ramp;
    @(posedge clk) disable iff (!rst_b)
    (s.phase == RAMP && waitOption && !regulatorReady) |=> (s.phase == RAMP);
  endproperty
  a_ramp: assert property (p_ramp) else $error("sent before regulator ready");

  property p_latch;
    @(posedge clk) disable iff (!rst_b)
    (lowSupplyLatchOption && lowSupplyRaw) ##1 lowSupplyLatchOption |-> lowSupplyFlag;
  endproperty
  a_latch: assert property (p_latch) else $error("low supply not latched");

  property p_wordEnd;
    @(posedge clk) disable iff (!rst_b)
    (pushValid && pushReady && s.bitIdx == s.wordLen - 7'h01) |=> (s.phase == IDLE);
  endproperty
  a_wordEnd: assert property (p_wordEnd) else $error("word did not end");
endmodule

// >>> dv/rf_sink_model.sv
`timescale 1ns/1ps
module rf_sink_model #(
  // Arbitrary key values, only used to make the two configurations differ
  parameter logic [31:0] KEY0 = 32'h5a3c9617,
  parameter logic [31:0] KEY1 = 32'hc3e1784b
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bench control
  input wire logic slow,
  input wire logic clear,
  // Cipher side
  input wire logic cipherReq,
  input wire logic cipherKeySel,
  input wire logic [31:0] cipherData,
  output logic cipherDone,
  output logic [31:0] cipherResult,
  // Bit stream side
  input wire logic txValid,
  output logic txReady,
  input wire logic txBit,
  // Observed traffic
  output logic [68:0] frame,
  output logic [6:0] bitCount,
  output logic [31:0] reqData,
  output logic reqSel,
  output logic [7:0] reqNum
);
  // ****************************************
  // Cipher stand-in and receiver
  // ****************************************
  logic [3:0] lat;
  logic [3:0] pace;
  logic [31:0] held;
  // Outside its answer cycle the result shows junk, so a late sample is caught
  assign cipherResult = cipherDone ? held : ~held;
  // Slow mode stalls the stream most cycles to fill the fifo
  assign txReady = !slow || (pace[1:0] == 2'h0);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lat <= 4'h0;
      pace <= 4'h0;
      held <= 32'h0;
      cipherDone <= 1'b0;
      frame <= '0;
      bitCount <= 7'h0;
      reqData <= 32'h0;
      reqSel <= 1'b0;
      reqNum <= 8'h0;
    end else begin
      pace <= pace + 4'h1;
      cipherDone <= (lat == 4'h1);
      if (lat == 4'h1) held <= reqData ^ (reqSel ? KEY1 : KEY0);
      if (cipherReq) begin
        lat <= slow ? 4'h6 : 4'h1;
        reqData <= cipherData;
        reqSel <= cipherKeySel;
        reqNum <= reqNum + 8'h1;
      end else if (lat != 4'h0) begin
        lat <= lat - 4'h1;
      end
      if (clear) begin
        frame <= '0;
        bitCount <= 7'h0;
      end else if (txValid && txReady) begin
        frame[bitCount] <= txBit;
        bitCount <= bitCount + 7'h1;
      end
    end
  end
endmodule

// >>> dv/hopping_code_word_assembler_tb.sv
`timescale 1ns/1ps
module hopping_code_word_assembler_tb;
  import hcwa_pkg::*;
  localparam logic [31:0] KEY0 = 32'h5a3c9617;
  localparam logic [31:0] KEY1 = 32'hc3e1784b;
  logic clk, rst_b, shift, pressDone, resend, busy, counterWidthOption, lowSupplyLatchOption;
  logic tripPointOption, waitOption, progWrite, progSel, lowSupplyRaw, tripHigh, lowSupplyFlag;
  logic regulatorReady, cipherReq, cipherKeySel, cipherDone, txValid, txReady, txBit, slow, clear, reqSel;
  logic [5:0] buttons;
  logic [1:0][31:0] serialNumber;
  logic [1:0][9:0] discriminationValue;
  logic [1:0] extendedSerialOption, queueBitsOption, progOverflow, queueCount;
  logic [1:0][1:0] overflowState;
  logic [19:0] progCount, wordCount;
  logic [31:0] cipherData, cipherResult, hopCode, reqData, rnd, lastHop;
  logic [68:0] frame;
  logic [6:0] bitCount;
  logic [7:0] reqNum, startNum;
  logic [19:0] cnt [2];
  logic [1:0] ovf [2];
  int errCount = 0;
  int totalChecks = 0;
  int cycles = 0;

  hopping_code_word_assembler #(.DEPTH(FIFO_DEPTH)) dut (.clk, .rst_b, .shift, .pressDone, .buttons, .resend,
    .busy, .serialNumber, .discriminationValue, .extendedSerialOption, .queueBitsOption, .counterWidthOption,
    .lowSupplyLatchOption, .tripPointOption, .waitOption, .progWrite, .progSel, .progCount, .progOverflow,
    .lowSupplyRaw, .tripHigh, .lowSupplyFlag, .regulatorReady, .queueCount, .cipherReq, .cipherKeySel,
    .cipherData, .cipherDone, .cipherResult, .hopCode, .wordCount, .overflowState, .txValid, .txReady, .txBit);
  rf_sink_model #(.KEY0(KEY0), .KEY1(KEY1)) partner (.clk, .rst_b, .slow, .clear, .cipherReq, .cipherKeySel,
    .cipherData, .cipherDone, .cipherResult, .txValid, .txReady, .txBit, .frame, .bitCount, .reqData, .reqSel,
    .reqNum);

  // ****************************************
  // Clock, hang guard, helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errCount++;
      endOfTest();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
  endfunction
  function automatic logic [3:0] funcCode(input logic [5:0] b);
    logic [5:0][3:0] t;
    logic [3:0] f;
    t = {4'hd, 4'he, 4'h1, 4'h8, 4'h4, 4'h2};
    f = 4'h0;
    for (int i = 0; i < 6; i++) if (b[i]) f |= t[i];
    return f;
  endfunction
  function automatic logic [31:0] plain(input logic c, input logic [3:0] f);
    if (counterWidthOption) return {f, discriminationValue[c][7:0], cnt[c]};
    return {f, ovf[c][1], ovf[c][0], discriminationValue[c], cnt[c][15:0]};
  endfunction
  task automatic chk(input string what, input logic [68:0] e, input logic [68:0] g);
    totalChecks++;
    if (g !== e) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic prog(input logic c, input logic [19:0] v, input logic [1:0] o);
    progSel = c;
    progCount = v;
    progOverflow = o;
    progWrite = 1'b1;
    step();
    progWrite = 1'b0;
    step();
    cnt[c] = v;
    ovf[c] = o;
  endtask
  task automatic bump(input logic c);
    if (!counterWidthOption && cnt[c][15:0] == 16'hffff) begin
      if (ovf[c][0]) ovf[c][0] = 1'b0;
      else ovf[c][1] = 1'b0;
    end
    cnt[c] = counterWidthOption ? cnt[c] + 20'h1 : {cnt[c][19:16], cnt[c][15:0] + 16'h1};
  endtask
  // One word from press (or resend) to the last bit at the receiver
  task automatic word(input logic c, input logic [5:0] b, input logic rs);
    logic [3:0] f;
    logic [31:0] p, h, fx;
    logic [6:0] len;
    logic [19:0] m;
    f = funcCode(b);
    clear = 1'b1;
    shift = c;
    buttons = b;
    if (rs) resend = 1'b1;
    else pressDone = 1'b1;
    step();
    clear = 1'b0;
    resend = 1'b0;
    pressDone = 1'b0;
    if (!rs) bump(c);
    p = plain(c, f);
    h = rs ? lastHop : p ^ (c ? KEY1 : KEY0);
    fx = extendedSerialOption[c] ? serialNumber[c] : {f, serialNumber[c][27:0]};
    len = queueBitsOption[c] ? 7'h45 : 7'h43;
    if (waitOption) begin
      repeat (30) step();
      pressDone = 1'b1;
      step();
      pressDone = 1'b0;
      chk("stalled", 7'h0, bitCount);
      chk("busy", 1'b1, busy);
      regulatorReady = 1'b1;
    end
    for (int n = 0; n < 3000; n++) begin
      if (busy === 1'b0 && txValid === 1'b0 && bitCount == len) break;
      step();
    end
    m = counterWidthOption ? 20'hfffff : 20'h0ffff;
    chk("bits", len, bitCount);
    chk("frame", {queueBitsOption[c] ? queueCount : 2'h0, ^fx, ^h, lowSupplyRaw, fx, h}, frame);
    if (!rs) chk("plain", p, reqData);
    if (!rs) chk("keysel", c, reqSel);
    chk("hop", h, hopCode);
    chk("count", cnt[c] & m, wordCount & m);
    chk("ovf", ovf[c], overflowState[c]);
    lastHop = h;
  endtask
  task automatic endOfTest();
    if (errCount == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_b, shift, pressDone, resend, buttons, progWrite, progSel, progCount, progOverflow} = '0;
    {counterWidthOption, lowSupplyLatchOption, tripPointOption, waitOption, lowSupplyRaw, slow, clear} = '0;
    {serialNumber, discriminationValue, extendedSerialOption, queueBitsOption, queueCount} = '0;
    regulatorReady = 1'b1;
    lastHop = 32'h0;
    rnd = 32'h3ebb5dbf;
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    chk("ovfreset", 4'hf, overflowState);
    // Both widths, both configurations stepping past 16'hffff; only configuration 1 wraps the long counter
    for (int w = 0; w < 2; w++) begin
      counterWidthOption = w[0];
      prog(1'b0, 20'h0fffe, 2'h3);
      prog(1'b1, 20'hffffe, 2'h3);
      for (int i = 0; i < 6; i++) begin
        rnd = lfsr(rnd);
        serialNumber[0] = rnd;
        rnd = lfsr(rnd);
        serialNumber[1] = rnd;
        rnd = lfsr(rnd);
        {tripPointOption, slow, lowSupplyRaw, queueCount, queueBitsOption, extendedSerialOption} = rnd[28:20];
        discriminationValue = rnd[19:0];
        buttons = w ? rnd[31:26] : 6'h01 << i;
        if (buttons == 6'h00) buttons = 6'h3f;
        word(i[0], buttons, 1'b0);
        chk("trip", tripPointOption, tripHigh);
      end
    end
    // Overflow flags clear one at a time and then stay clear
    counterWidthOption = 1'b0;
    ovf[0] = 2'h3;
    for (int k = 0; k < 3; k++) begin
      prog(1'b0, 20'h0ffff, ovf[0]);
      word(1'b0, 6'h04, 1'b0);
    end
    startNum = reqNum;
    word(1'b0, 6'h04, 1'b1);
    chk("reqs", startNum, reqNum);
    // Regulator wait, with a press while busy that must be ignored
    waitOption = 1'b1;
    regulatorReady = 1'b0;
    startNum = reqNum;
    word(1'b1, 6'h30, 1'b0);
    chk("reqs", startNum + 8'h1, reqNum);
    waitOption = 1'b0;
    // Low supply latch
    lowSupplyLatchOption = 1'b1;
    lowSupplyRaw = 1'b1;
    step();
    lowSupplyRaw = 1'b0;
    step();
    chk("latched", 1'b1, lowSupplyFlag);
    lowSupplyLatchOption = 1'b0;
    step();
    chk("unlatched", 1'b0, lowSupplyFlag);
    endOfTest();
  end
endmodule
